// ===== rtl/dcs_pkg.sv
// Contract
// - Writing one to bit 15 of the sleep control register puts the serial port to sleep, zero keeps it normal.
// - The sleep control register comes out of reset as zero, so the port starts in normal mode.
// - The reset pin clears the sleep bit and a low rouse pin holds it at zero.
// - Awake, serial input shifts into the shift register; asleep, serial input goes straight to serial output.
// - A write to index 07h loads word bits 15 to 4 into all eight channel data registers at once.
// - Broadcast writes take effect only while the correction enable bit is zero and are ignored otherwise.
// - The broadcast register is write-only and always reads as zero.
// - With correction enabled a channel write passes through the correction engine, otherwise it is stored directly.
// - Transfer into a channel latch moves that channel's output code to the new latch contents.
// - Each channel input register keeps a 12-bit code in word bits 15 to 4, ignores bits 3 to 0 and resets to zero.
// - There are eight zero registers and eight gain registers, one of each per channel 0 to 7.
// - Each zero register holds a twos complement offset from 800h to 7FFh, one step per LSB, reset to zero.
// - Each gain register holds a straight binary coefficient, 000h is 0.5, 800h is unity and the reset value.
// - With the rouse pin high and select wake enabled, a select rising edge after at most one clock fall ends sleep.
package dcs_pkg;

  localparam int FRAME_BITS = 24;
  localparam logic [4:0] FRAME_LAST = 5'h17;
  localparam logic [4:0] FRAME_DONE = 5'h18;

  localparam logic [4:0] IDX_CONFIG = 5'h00;
  localparam logic [4:0] IDX_SLEEP = 5'h04;
  localparam logic [4:0] IDX_BCAST = 5'h07;
  localparam logic [1:0] GRP_INPUT = 2'h1;
  localparam logic [1:0] GRP_ZERO = 2'h2;
  localparam logic [1:0] GRP_GAIN = 2'h3;

  localparam int SLEEP_BIT = 15;
  localparam int ROUSE_EN_BIT = 4;
  localparam int CORR_BIT = 8;
  localparam int CODE_LSB = 4;

  localparam logic [11:0] CODE_RST = 12'h000;
  localparam logic [11:0] ZERO_RST = 12'h000;
  localparam logic [11:0] GAIN_RST = 12'h800;
  localparam logic [15:0] SLEEP_CTRL_RST = 16'h0000;
  localparam logic [15:0] READ_ZERO = 16'h0000;
  localparam logic [12:0] GAIN_HALF = 13'h0800;
  localparam logic [11:0] CODE_MAX = 12'hfff;
  localparam logic [1:0] FALL_LIMIT = 2'h1;
  localparam logic [1:0] FALL_SAT = 2'h2;

  typedef logic [11:0] dcs_code_t;

  typedef struct packed {
    logic rd;
    logic [1:0] spare;
    logic [4:0] idx;
    logic [15:0] data;
  } dcs_frame_t;

endpackage

// ===== rtl/dcs_regs.sv
`timescale 1ns/10ps
module dcs_regs
#(
  parameter int CHANNELS = 8
)
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic serial_in_pin,
  input wire logic rouse_pin_b,
  input wire logic latch_load_b,
  output logic serial_out_pin,
  output dcs_pkg::dcs_code_t [CHANNELS-1:0] dac_latch,
  output logic sleep_active,
  output logic correction_enable_bit
);
  import dcs_pkg::*;

  localparam int S_CS = 0;
  localparam int S_SCLK = 1;
  localparam int S_TGL = 2;
  localparam int S_ROUSE = 3;
  localparam int S_LOAD = 4;

  dcs_frame_t frame;
  logic frame_tgl;
  logic [4:0] pins_in;
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  logic [4:0] prev_r;
  logic frame_evt;
  logic cs_rise;
  logic cs_fall;
  logic sclk_fall;

  logic sleep_r;
  logic sleep_nxt;
  logic rouse_en_r;
  logic rouse_en_nxt;
  logic corr_r;
  logic corr_nxt;
  logic [1:0] falls_r;
  logic [1:0] falls_nxt;
  logic [15:0] rd_word_r;
  logic [15:0] rd_word_nxt;
  dcs_code_t [CHANNELS-1:0] input_r;
  dcs_code_t [CHANNELS-1:0] input_nxt;
  dcs_code_t [CHANNELS-1:0] data_r;
  dcs_code_t [CHANNELS-1:0] data_nxt;
  dcs_code_t [CHANNELS-1:0] zero_r;
  dcs_code_t [CHANNELS-1:0] zero_nxt;
  dcs_code_t [CHANNELS-1:0] gain_r;
  dcs_code_t [CHANNELS-1:0] gain_nxt;
  dcs_code_t [CHANNELS-1:0] latch_r;
  dcs_code_t [CHANNELS-1:0] latch_nxt;

  // Gain scaling plus offset, clamped to the code range
  function automatic dcs_code_t dcs_correct(input dcs_code_t code, input dcs_code_t gain, input dcs_code_t zero);
    logic [24:0] prod;
    logic signed [14:0] sum;
    prod = 25'(code) * 25'({1'b0, gain} + GAIN_HALF);
    sum = $signed({2'b00, prod[24:12]}) + $signed({{3{zero[11]}}, zero});
    if (sum < 0)
      dcs_correct = CODE_RST;
    else if (sum > $signed({3'b000, CODE_MAX}))
      dcs_correct = CODE_MAX;
    else
      dcs_correct = sum[11:0];
  endfunction

  // Register readback by index
  function automatic logic [15:0] dcs_read(input logic [4:0] idx, input logic sleep, input logic rouse_en,
                                           input logic corr, input dcs_code_t [CHANNELS-1:0] inp,
                                           input dcs_code_t [CHANNELS-1:0] zer, input dcs_code_t [CHANNELS-1:0] gan);
    dcs_read = READ_ZERO;
    if (idx == IDX_CONFIG)
      dcs_read[CORR_BIT] = corr;
    else if (idx == IDX_SLEEP)
    begin
      dcs_read[SLEEP_BIT] = sleep;
      dcs_read[ROUSE_EN_BIT] = rouse_en;
    end
    else if (idx == IDX_BCAST)
      dcs_read = READ_ZERO;
    else if (idx[4:3] == GRP_INPUT)
      dcs_read = {inp[idx[2:0]], 4'h0};
    else if (idx[4:3] == GRP_ZERO)
      dcs_read = {zer[idx[2:0]], 4'h0};
    else if (idx[4:3] == GRP_GAIN)
      dcs_read = {gan[idx[2:0]], 4'h0};
  endfunction

  dcs_spi_link u_link
  (
    .sclk(sclk),
    .rst_b(rst_b),
    .cs_b(cs_b),
    .serial_in_pin(serial_in_pin),
    .sleep_sel(sleep_r),
    .tx_word(rd_word_r),
    .serial_out_pin(serial_out_pin),
    .frame(frame),
    .frame_tgl(frame_tgl)
  );

  // Two-stage synchronisers for pins and the frame toggle
  assign pins_in = {latch_load_b, rouse_pin_b, frame_tgl, sclk, cs_b};

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1_r <= 5'h19;
      sync2_r <= 5'h19;
      prev_r <= 5'h19;
    end
    else
    begin
      sync1_r <= pins_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  assign frame_evt = sync2_r[S_TGL] ^ prev_r[S_TGL];
  assign cs_rise = sync2_r[S_CS] & ~prev_r[S_CS];
  assign cs_fall = ~sync2_r[S_CS] & prev_r[S_CS];
  assign sclk_fall = ~sync2_r[S_SCLK] & prev_r[S_SCLK];

  // Next state of the register file
  always_comb
  begin
    sleep_nxt = sleep_r;
    rouse_en_nxt = rouse_en_r;
    corr_nxt = corr_r;
    falls_nxt = falls_r;
    rd_word_nxt = rd_word_r;
    input_nxt = input_r;
    data_nxt = data_r;
    zero_nxt = zero_r;
    gain_nxt = gain_r;
    latch_nxt = latch_r;

    // Count clock falls inside one select window
    if (cs_fall)
      falls_nxt = 2'h0;
    else if (!sync2_r[S_CS] && sclk_fall && falls_r < FALL_SAT)
      falls_nxt = falls_r + 2'h1;

    if (cs_rise && sleep_r && rouse_en_r && sync2_r[S_ROUSE] && falls_r <= FALL_LIMIT)
      sleep_nxt = 1'b0;

    // Frames are dropped while asleep; the shifter still captures them but decode is gated off
    if (frame_evt && !sleep_r)
    begin
      if (frame.rd)
        rd_word_nxt = dcs_read(frame.idx, sleep_r, rouse_en_r, corr_r, input_r, zero_r, gain_r);
      else if (frame.idx == IDX_CONFIG)
        corr_nxt = frame.data[CORR_BIT];
      else if (frame.idx == IDX_SLEEP)
      begin
        sleep_nxt = frame.data[SLEEP_BIT];
        rouse_en_nxt = frame.data[ROUSE_EN_BIT];
      end
      else if (frame.idx == IDX_BCAST)
      begin
        if (!corr_r)
        begin
          for (int i = 0; i < CHANNELS; i++)
          begin
            input_nxt[i] = frame.data[15:CODE_LSB];
            data_nxt[i] = frame.data[15:CODE_LSB];
          end
        end
      end
      else if (frame.idx[4:3] == GRP_INPUT)
      begin
        input_nxt[frame.idx[2:0]] = frame.data[15:CODE_LSB];
        if (corr_r)
          data_nxt[frame.idx[2:0]] = dcs_correct(frame.data[15:CODE_LSB], gain_r[frame.idx[2:0]],
                                                 zero_r[frame.idx[2:0]]);
        else
          data_nxt[frame.idx[2:0]] = frame.data[15:CODE_LSB];
      end
      else if (frame.idx[4:3] == GRP_ZERO)
        zero_nxt[frame.idx[2:0]] = frame.data[15:CODE_LSB];
      else if (frame.idx[4:3] == GRP_GAIN)
        gain_nxt[frame.idx[2:0]] = frame.data[15:CODE_LSB];
    end

    // Low rouse pin holds the port awake
    if (!sync2_r[S_ROUSE])
      sleep_nxt = 1'b0;

    // Latches follow the data registers while load is held low
    if (!sync2_r[S_LOAD])
      latch_nxt = data_r;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sleep_r <= SLEEP_CTRL_RST[SLEEP_BIT];
      rouse_en_r <= SLEEP_CTRL_RST[ROUSE_EN_BIT];
      corr_r <= 1'b0;
      falls_r <= 2'h0;
      rd_word_r <= READ_ZERO;
      for (int i = 0; i < CHANNELS; i++)
      begin
        input_r[i] <= CODE_RST;
        data_r[i] <= CODE_RST;
        zero_r[i] <= ZERO_RST;
        gain_r[i] <= GAIN_RST;
        latch_r[i] <= CODE_RST;
      end
    end
    else
    begin
      sleep_r <= sleep_nxt;
      rouse_en_r <= rouse_en_nxt;
      corr_r <= corr_nxt;
      falls_r <= falls_nxt;
      rd_word_r <= rd_word_nxt;
      input_r <= input_nxt;
      data_r <= data_nxt;
      zero_r <= zero_nxt;
      gain_r <= gain_nxt;
      latch_r <= latch_nxt;
    end
  end

  assign dac_latch = latch_r;
  assign sleep_active = sleep_r;
  assign correction_enable_bit = corr_r;

endmodule

// ===== rtl/dcs_spi_link.sv
`timescale 1ns/10ps
module dcs_spi_link
(
  input wire logic sclk,
  input wire logic rst_b,
  input wire logic cs_b,
  input wire logic serial_in_pin,
  input wire logic sleep_sel,
  input wire logic [15:0] tx_word,
  output logic serial_out_pin,
  output dcs_pkg::dcs_frame_t frame,
  output logic frame_tgl
);
  import dcs_pkg::*;

  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic [22:0] sh_r;
  logic [22:0] sh_nxt;
  dcs_frame_t frame_r;
  dcs_frame_t frame_nxt;
  logic tgl_r;
  logic tgl_nxt;
  logic link_clr;
  logic [23:0] tx_full;
  logic [4:0] tx_idx;

  assign link_clr = cs_b | ~rst_b;

  // Bit counter restarts whenever select is high
  always_comb
  begin
    cnt_nxt = (cnt_r < FRAME_DONE) ? cnt_r + 5'h01 : cnt_r;
  end

  always_ff @(posedge sclk or posedge link_clr)
  begin
    if (link_clr)
      cnt_r <= 5'h00;
    else
      cnt_r <= cnt_nxt;
  end

  // Serial input shifts in, full word captured on the last bit
  always_comb
  begin
    sh_nxt = {sh_r[21:0], serial_in_pin};
    frame_nxt = frame_r;
    tgl_nxt = tgl_r;
    if (cnt_r == FRAME_LAST)
    begin
      frame_nxt = dcs_frame_t'({sh_r, serial_in_pin});
      tgl_nxt = ~tgl_r;
    end
  end

  always_ff @(posedge sclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sh_r <= 23'h000000;
      frame_r <= dcs_frame_t'(24'h000000);
      tgl_r <= 1'b0;
    end
    else
    begin
      sh_r <= sh_nxt;
      frame_r <= frame_nxt;
      tgl_r <= tgl_nxt;
    end
  end

  // Readback word leaves msb first, or input is bypassed while asleep
  assign tx_full = {8'h00, tx_word};
  assign tx_idx = (cnt_r < FRAME_DONE) ? FRAME_LAST - cnt_r : 5'h00;
  assign serial_out_pin = sleep_sel ? serial_in_pin : tx_full[tx_idx];
  assign frame = frame_r;
  assign frame_tgl = tgl_r;

endmodule

// ===== verification/dcs_host.sv
`timescale 1ns/10ps
module dcs_host
(
  output logic sclk,
  output logic cs_b,
  output logic serial_in_pin,
  input wire logic serial_out_pin
);
  initial
  begin
    sclk = 1'b0;
    cs_b = 1'b1;
    serial_in_pin = 1'b0;
  end
  task automatic xfer(input logic [23:0] w, output logic [23:0] r);
    #7;
    cs_b = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      serial_in_pin = w[i];
      #80;
      r[i] = serial_out_pin;
      sclk = 1'b1;
      #80;
      sclk = 1'b0;
    end
    #80;
    cs_b = 1'b1;
    serial_in_pin = ~w[0];
    #400;
  endtask
  // Select pulse with no clock edge
  task automatic pulse;
    #7;
    cs_b = 1'b0;
    #320;
    cs_b = 1'b1;
    #400;
  endtask
endmodule

// ===== verification/dcs_regs_props.sv
`timescale 1ns/10ps
module dcs_regs_props
#(
  parameter int CHANNELS = 8
)
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic serial_in_pin,
  input wire logic rouse_pin_b,
  input wire logic latch_load_b,
  input wire logic serial_out_pin,
  input wire dcs_pkg::dcs_code_t [CHANNELS-1:0] dac_latch,
  input wire logic sleep_active,
  input wire logic correction_enable_bit
);
  import dcs_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_rst;
    $rose(rst_b) |-> dac_latch == '0 && !sleep_active && !correction_enable_bit;
  endproperty
  property p_rouse;
    !rouse_pin_b [*4] |-> !sleep_active;
  endproperty
  property p_bypass;
    sleep_active |-> serial_out_pin == serial_in_pin;
  endproperty
  property p_hold;
    latch_load_b [*4] |=> $stable(dac_latch);
  endproperty
  property p_corr_sleep;
    $past(sleep_active) |-> $stable(correction_enable_bit);
  endproperty
  property p_latch_sleep;
    sleep_active [*6] |-> $stable(dac_latch);
  endproperty
  property p_wake;
    $fell(sleep_active) |-> !$past(rouse_pin_b) || !$past(rouse_pin_b, 2) || !$past(rouse_pin_b, 3) || $past(cs_b);
  endproperty
  property p_corr_idle;
    cs_b [*8] |=> $stable(correction_enable_bit);
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  a_rouse: assert property (p_rouse) else $error("sleep with rouse low");
  a_bypass: assert property (p_bypass) else $error("no bypass asleep");
  a_hold: assert property (p_hold) else $error("latch moved without load");
  a_corr_sleep: assert property (p_corr_sleep) else $error("frame decoded asleep");
  a_latch_sleep: assert property (p_latch_sleep) else $error("latch moved asleep");
  a_wake: assert property (p_wake) else $error("wake without cause");
  a_corr_idle: assert property (p_corr_idle) else $error("enable moved idle");
  c_sleep: cover property ($rose(sleep_active));
  c_wake: cover property ($fell(sleep_active));
  c_corr: cover property ($rose(correction_enable_bit));
endmodule
bind dcs_regs dcs_regs_props #(.CHANNELS(CHANNELS)) u_dcs_regs_props (.clock(clock), .rst_b(rst_b), .sclk(sclk),
  .cs_b(cs_b), .serial_in_pin(serial_in_pin), .rouse_pin_b(rouse_pin_b), .latch_load_b(latch_load_b),
  .serial_out_pin(serial_out_pin), .dac_latch(dac_latch), .sleep_active(sleep_active),
  .correction_enable_bit(correction_enable_bit));

// ===== verification/dcs_regs_tb.sv
`timescale 1ns/10ps
module dcs_regs_tb;
  import dcs_pkg::*;
  logic clock, rst_b, rouse_pin_b, latch_load_b, sclk, cs_b, serial_in_pin, serial_out_pin, sleep_active, corr;
  dcs_code_t [7:0] dac_latch;
  int err_total = 0;
  int cmp_count = 0;
  logic [15:0] lf = 16'h0015;
  logic [15:0] d;
  logic [23:0] rx;
  logic [11:0] c, g, z;
  logic [11:0] lat [8];
  dcs_regs #(.CHANNELS(8)) u_dcs_regs (.clock(clock), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b),
    .serial_in_pin(serial_in_pin), .rouse_pin_b(rouse_pin_b), .latch_load_b(latch_load_b),
    .serial_out_pin(serial_out_pin), .dac_latch(dac_latch), .sleep_active(sleep_active),
    .correction_enable_bit(corr));
  dcs_host u_dcs_host (.sclk(sclk), .cs_b(cs_b), .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin));
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [11:0] corr_code(input logic [11:0] cd, input logic [11:0] gn, input logic [11:0] zr);
    int v;
    v = int'(cd) * (int'(gn) + 2048) / 4096 + int'($signed(zr));
    return (v < 0) ? 12'h000 : (v > 4095) ? 12'hfff : 12'(v);
  endfunction
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic chk_all;
    for (int i = 0; i < 8; i++)
      chk_word(16'(dac_latch[i]), 16'(lat[i]));
  endtask
  task automatic wr(input logic [4:0] idx, input logic [15:0] dw);
    u_dcs_host.xfer({3'h0, idx, dw}, rx);
    repeat (10) @(negedge clock);
  endtask
  task automatic rd(input logic [4:0] idx, output logic [15:0] dr);
    u_dcs_host.xfer({3'h4, idx, 16'h0000}, rx);
    u_dcs_host.xfer({3'h4, idx, 16'h0000}, rx);
    repeat (10) @(negedge clock);
    dr = rx[15:0];
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #2000000;
    err_total++;
    end_of_test;
  end
  initial
  begin
    rst_b = 1'b0;
    rouse_pin_b = 1'b1;
    latch_load_b = 1'b0;
    for (int i = 0; i < 8; i++)
      lat[i] = 12'h000;
    repeat (4) @(negedge clock);
    rst_b = 1'b1;
    repeat (4) @(negedge clock);
    chk_all;
    rd(5'h18, d);
    chk_word(d, 16'h8000);
    rd(5'h04, d);
    chk_word(d, 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      lf = lfsr(lf);
      lat[i] = lf[15:4];
      u_dcs_host.xfer({3'h0, 5'(8 + i), lf}, rx);
      repeat (10) @(negedge clock);
      chk_word(16'(dac_latch[i]), 16'(lat[i]));
      u_dcs_host.xfer({3'h4, 5'(8 + i), 16'h0000}, rx);
      u_dcs_host.xfer({3'h4, 5'(8 + i), 16'h0000}, rx);
      chk_word(rx[15:0], {lat[i], 4'h0});
    end
    $display("test direct done");
    latch_load_b = 1'b1;
    lf = lfsr(lf);
    wr(5'h07, lf);
    chk_all;
    latch_load_b = 1'b0;
    repeat (6) @(negedge clock);
    for (int i = 0; i < 8; i++)
      lat[i] = lf[15:4];
    chk_all;
    rd(5'h07, d);
    chk_word(d, 16'h0000);
    $display("test broadcast done");
    wr(5'h00, 16'h0100);
    chk_bit(corr, 1'b1);
    for (int k = 0; k < 8; k++)
    begin
      lf = lfsr(lf);
      c = (k == 0) ? 12'hfff : (k == 1) ? 12'h000 : lf[11:0];
      g = (k == 0) ? 12'hfff : (k == 1) ? 12'h000 : lf[15:4];
      z = (k == 0) ? 12'h7ff : (k == 1) ? 12'h800 : {lf[7:0], lf[15:12]};
      wr(5'(16 + k), {z, 4'h0});
      wr(5'(24 + k), {g, 4'h0});
      wr(5'(8 + k), {c, 4'h0});
      lat[k] = corr_code(c, g, z);
      chk_word(16'(dac_latch[k]), 16'(lat[k]));
    end
    rd(5'h11, d);
    chk_word(d, 16'h8000);
    wr(5'h07, 16'hfff0);
    chk_all;
    wr(5'h00, 16'h0000);
    $display("test correction done");
    wr(5'h04, 16'h8010);
    chk_bit(sleep_active, 1'b1);
    u_dcs_host.xfer({3'h0, 5'h08, 16'h5a50}, rx);
    repeat (10) @(negedge clock);
    chk_word(rx[15:0], 16'h5a50);
    chk_all;
    chk_bit(sleep_active, 1'b1);
    u_dcs_host.pulse;
    repeat (8) @(negedge clock);
    chk_bit(sleep_active, 1'b0);
    wr(5'h04, 16'h8000);
    rouse_pin_b = 1'b0;
    repeat (6) @(negedge clock);
    chk_bit(sleep_active, 1'b0);
    wr(5'h04, 16'h8000);
    chk_bit(sleep_active, 1'b0);
    rouse_pin_b = 1'b1;
    $display("test sleep done");
    end_of_test;
  end
endmodule
